// >>> src/gio_pkg.sv
// Constants, types and line tables for the grabber I/O line controller
package gio_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_LINE_SEL   = 8'h00;
    localparam logic [7:0] OFS_LINE_DIR   = 8'h04;
    localparam logic [7:0] OFS_FILT_WIDTH = 8'h08;
    localparam logic [7:0] OFS_OUT_SRC    = 8'h0c;
    localparam logic [7:0] OFS_LVL_STD    = 8'h10;
    localparam logic [7:0] OFS_LINE_STATE = 8'h14;
    localparam logic [7:0] OFS_USER_SEL   = 8'h18;
    localparam logic [7:0] OFS_USER_VAL   = 8'h1c;

    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int SEL_W    = 5;
    localparam int SRC_W    = 6;
    localparam int USEL_W   = 5;
    localparam int FILT_W   = 19;
    localparam int CNT_W    = 20;
    localparam int NUM_TMR  = 4;
    localparam int NUM_GRP  = 4;

    // Variant sizes
    localparam int LINES_LARGE = 20;
    localparam int LINES_SMALL = 10;

    // Filter timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int FILT_STEP_NS   = 20;
    localparam int FILT_MAX_US    = 10000;
    localparam int FILT_MAX_STEPS = FILT_MAX_US * 1000 / FILT_STEP_NS;
    localparam int STEPS_PER_CLK  = CLK_PERIOD_NS / FILT_STEP_NS;

    // Reset values
    localparam logic [SEL_W-1:0]  RST_LINE_SEL = 5'h00;
    localparam logic [FILT_W-1:0] RST_FILT     = 19'h00000;
    localparam logic [USEL_W-1:0] RST_USER_SEL = 5'h00;
    localparam logic              RST_DIR      = 1'b0;

    // Direction field encoding
    localparam logic DIR_INPUT  = 1'b0;
    localparam logic DIR_OUTPUT = 1'b1;

    typedef enum logic [1:0] {
        GIO_STD_OPTO = 2'b00,
        GIO_STD_TTL  = 2'b01,
        GIO_STD_DIFF = 2'b10
    } gio_std_t;

    typedef enum logic [1:0] {
        GIO_KIND_IN    = 2'b00,
        GIO_KIND_OUT   = 2'b01,
        GIO_KIND_BIDIR = 2'b10
    } gio_kind_t;

    typedef struct packed {
        gio_std_t  std;
        gio_kind_t kind;
    } gio_line_t;

    // Fixed line table for either variant
    function automatic gio_line_t gio_line_info(input int n_lines,
                                                input int idx);
        gio_line_t r;
        int        p;
        r = '{std: GIO_STD_OPTO, kind: GIO_KIND_IN};
        if (n_lines == LINES_LARGE) begin
            p = idx % 10;
            if (p < 4) begin
                r = '{std: GIO_STD_OPTO, kind: GIO_KIND_IN};
            end else if (p < 6) begin
                r = '{std: GIO_STD_TTL, kind: GIO_KIND_BIDIR};
            end else if (p < 8) begin
                r = '{std: GIO_STD_OPTO, kind: GIO_KIND_OUT};
            end else begin
                r = '{std: GIO_STD_DIFF, kind: GIO_KIND_IN};
            end
        end else begin
            if (idx < 2) begin
                r = '{std: GIO_STD_DIFF, kind: GIO_KIND_IN};
            end else if (idx < 6) begin
                r = '{std: GIO_STD_OPTO, kind: GIO_KIND_OUT};
            end else begin
                r = '{std: GIO_STD_TTL, kind: GIO_KIND_BIDIR};
            end
        end
        return r;
    endfunction

endpackage

// >>> src/gio_edge_filter.sv
// Glitch filter for one input line, counting in 20 ns steps
`timescale 1ns/1ns
module gio_edge_filter #(
    parameter logic RST_LEVEL = 1'b0
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       level_in,
    input  wire logic [gio_pkg::FILT_W-1:0] width,
    output logic                            level_out
);

    logic [gio_pkg::CNT_W-1:0] cnt_reg;
    logic [gio_pkg::CNT_W-1:0] cnt_next;
    logic                      accept;

    // Each clock is several filter steps long
    assign cnt_next = cnt_reg + gio_pkg::CNT_W'(gio_pkg::STEPS_PER_CLK);
    // New level taken only once stable for the full width
    assign accept   = (cnt_next >= {1'b0, width});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
        end else if (level_in == level_out || accept) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_out <= RST_LEVEL;
        end else if (level_in != level_out && accept) begin
            level_out <= level_in;
        end
    end

endmodule // gio_edge_filter

// >>> src/gio_line_ctrl.sv
// Grabber I/O line controller: APB registers, filters, output routing
//
// Summary of operation
// - Large variant has twenty numbered lines
// - Small variant has ten onboard lines
// - Large: lines 4,5,14,15 bidir, input default
// - Small: lines 6 to 9 bidir, input default
// - Up to sixteen or six input lines
// - Eight output lines: four opto, four bidir
// - Fixed line direction read-only, reports actual
// - Bidir line acts as chosen direction
// - Line index selector resets to zero
// - Input filter width 0-10000 us, 20 ns
// - Pulses shorter than width are removed
// - Large sources: user bits, lines, timers, groups
// - Small sources: user bits, lines, timers, groups
// - Output source resets to timer zero
// - Output follows source without inversion
// - User bit source follows written user value
// - Line source copies that line's input
// - Timer source carries timer waveform
// - Group source follows its user value
// - Selected line level standard readable
// - Large: lines 8,9,18,19 reset true
// - Small: lines 0,1 reset true
// - Output line reports logic state false
`timescale 1ns/1ns
module gio_line_ctrl #(
    parameter int NUM_LINES = gio_pkg::LINES_LARGE
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [gio_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [gio_pkg::DATA_W-1:0]  pwdata,
    output logic      [gio_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [gio_pkg::NUM_TMR-1:0] timer_wave,
    input  wire logic [NUM_LINES-1:0]        line_in,
    output logic      [NUM_LINES-1:0]        line_out,
    output logic      [NUM_LINES-1:0]        line_oe
);

    localparam int NSRC = 2 * NUM_LINES + gio_pkg::NUM_TMR
                          + gio_pkg::NUM_GRP;
    localparam int NUSR = NUM_LINES + gio_pkg::NUM_GRP;
    localparam logic [gio_pkg::SRC_W-1:0] SRC_TIMER0 =
        gio_pkg::SRC_W'(2 * NUM_LINES);

    // Only the two documented line counts have line tables
    generate
        if (NUM_LINES != gio_pkg::LINES_LARGE &&
            NUM_LINES != gio_pkg::LINES_SMALL) begin : g_bad_lines
            $error("NUM_LINES must be 10 or 20");
        end
        if (NSRC > 2 ** gio_pkg::SRC_W ||
            NUSR > 2 ** gio_pkg::USEL_W) begin : g_bad_fields
            $error("fields too narrow");
        end
    endgenerate

    logic [gio_pkg::SEL_W-1:0]  line_sel_reg;
    logic [gio_pkg::USEL_W-1:0] user_sel_reg;

    logic [NUM_LINES-1:0]       dir_reg;
    logic [gio_pkg::FILT_W-1:0] filt_reg [NUM_LINES];
    logic [gio_pkg::SRC_W-1:0]  src_reg  [NUM_LINES];

    logic [NUM_LINES-1:0]       user_bits_reg;
    logic [gio_pkg::NUM_GRP-1:0] group_bits_reg;

    logic [NUM_LINES-1:0]       sync1_reg;
    logic [NUM_LINES-1:0]       sync2_reg;

    logic [NUM_LINES-1:0]       filt_level;
    logic [NUM_LINES-1:0]       is_output;
    logic [NUM_LINES-1:0]       line_state;
    logic [NSRC-1:0]            src_vec;

    logic [gio_pkg::DATA_W-1:0] rd_next;
    logic                       rd_err;
    logic                       wr_err;
    logic                       setup;
    logic                       wr_en;

    logic [gio_pkg::NUM_TMR-1:0] tmr1_reg;
    logic [gio_pkg::NUM_TMR-1:0] tmr2_reg;

    gio_pkg::gio_line_t          sel_info;

    // Decode in setup, commit in access
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;

    // Selected line table entry; out of range cannot occur
    always_comb begin
        sel_info = gio_pkg::gio_line_info(NUM_LINES, 0);
        for (int i = 0; i < NUM_LINES; i++) begin
            if (line_sel_reg == gio_pkg::SEL_W'(i)) begin
                sel_info = gio_pkg::gio_line_info(NUM_LINES, i);
            end
        end
    end

    // Pins come from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= line_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Timer waveforms assumed from another block; synchronise anyway
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmr1_reg <= '0;
            tmr2_reg <= '0;
        end else begin
            tmr1_reg <= timer_wave;
            tmr2_reg <= tmr1_reg;
        end
    end

    // Per-line filter, direction and status
    generate
        for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
            localparam gio_pkg::gio_line_t INFO =
                gio_pkg::gio_line_info(NUM_LINES, g);

            // Differential inputs idle true at power-on
            localparam logic RST_LVL =
                (INFO.std == gio_pkg::GIO_STD_DIFF);

            gio_edge_filter #(
                .RST_LEVEL (RST_LVL)
            ) u_filt (
                .pclk      (pclk),
                .presetn   (presetn),
                .level_in  (sync2_reg[g]),
                .width     (filt_reg[g]),
                .level_out (filt_level[g])
            );

            // Fixed kinds ignore the direction bit entirely
            assign is_output[g] =
                (INFO.kind == gio_pkg::GIO_KIND_OUT) ||
                (INFO.kind == gio_pkg::GIO_KIND_BIDIR &&
                 dir_reg[g] == gio_pkg::DIR_OUTPUT);

            // Drivers do not read their pin
            assign line_state[g] =
                is_output[g] ? 1'b0 : filt_level[g];

            assign line_oe[g] = is_output[g];

            // Fixed lines drop these writes
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir_reg[g] <= gio_pkg::RST_DIR;
                end else if (wr_en && paddr == gio_pkg::OFS_LINE_DIR &&
                             line_sel_reg == gio_pkg::SEL_W'(g) &&
                             INFO.kind == gio_pkg::GIO_KIND_BIDIR) begin
                    dir_reg[g] <= pwdata[0];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    filt_reg[g] <= gio_pkg::RST_FILT;
                end else if (wr_en && paddr == gio_pkg::OFS_FILT_WIDTH &&
                             line_sel_reg == gio_pkg::SEL_W'(g) &&
                             pwdata <= gio_pkg::DATA_W'(
                                 gio_pkg::FILT_MAX_STEPS)) begin
                    filt_reg[g] <= pwdata[gio_pkg::FILT_W-1:0];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src_reg[g] <= SRC_TIMER0;
                end else if (wr_en && paddr == gio_pkg::OFS_OUT_SRC &&
                             line_sel_reg == gio_pkg::SEL_W'(g) &&
                             pwdata < gio_pkg::DATA_W'(NSRC)) begin
                    src_reg[g] <= pwdata[gio_pkg::SRC_W-1:0];
                end
            end

            // Registered pin drive; inputs and idle drive low
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    line_out[g] <= 1'b0;
                end else if (is_output[g]) begin
                    line_out[g] <= src_vec[src_reg[g]];
                end else begin
                    line_out[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Source order: user bits, line levels, timers, group levels
    assign src_vec = {group_bits_reg,
                      tmr2_reg,
                      filt_level,
                      user_bits_reg};

    // Line index selector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_sel_reg <= gio_pkg::RST_LINE_SEL;
        end else if (wr_en && paddr == gio_pkg::OFS_LINE_SEL &&
                     pwdata < gio_pkg::DATA_W'(NUM_LINES)) begin
            line_sel_reg <= pwdata[gio_pkg::SEL_W-1:0];
        end
    end

    // User level selector: user bits then group entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_sel_reg <= gio_pkg::RST_USER_SEL;
        end else if (wr_en && paddr == gio_pkg::OFS_USER_SEL &&
                     pwdata < gio_pkg::DATA_W'(NUSR)) begin
            user_sel_reg <= pwdata[gio_pkg::USEL_W-1:0];
        end
    end

    // Writes of the user level value land in the selected entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            user_bits_reg  <= '0;
            group_bits_reg <= '0;
        end else if (wr_en && paddr == gio_pkg::OFS_USER_VAL) begin
            for (int i = 0; i < NUM_LINES; i++) begin
                if (user_sel_reg == gio_pkg::USEL_W'(i)) begin
                    user_bits_reg[i] <= pwdata[0];
                end
            end
            for (int j = 0; j < gio_pkg::NUM_GRP; j++) begin
                if (user_sel_reg == gio_pkg::USEL_W'(NUM_LINES + j)) begin
                    group_bits_reg[j] <= pwdata[0];
                end
            end
        end
    end

    // Read mux and decode errors
    always_comb begin
        rd_next = '0;
        rd_err  = 1'b0;
        case (paddr)
            gio_pkg::OFS_LINE_SEL: begin
                rd_next[gio_pkg::SEL_W-1:0] = line_sel_reg;
            end
            gio_pkg::OFS_LINE_DIR: begin
                // Bit 1: is bit 0 writable
                rd_next[0] = is_output[line_sel_reg];
                rd_next[1] = (sel_info.kind == gio_pkg::GIO_KIND_BIDIR);
            end
            gio_pkg::OFS_FILT_WIDTH: begin
                rd_next[gio_pkg::FILT_W-1:0] = filt_reg[line_sel_reg];
            end
            gio_pkg::OFS_OUT_SRC: begin
                rd_next[gio_pkg::SRC_W-1:0] = src_reg[line_sel_reg];
            end
            gio_pkg::OFS_LVL_STD: begin
                rd_next[1:0] = sel_info.std;
            end
            gio_pkg::OFS_LINE_STATE: begin
                rd_next[NUM_LINES-1:0] = line_state;
            end
            gio_pkg::OFS_USER_SEL: begin
                rd_next[gio_pkg::USEL_W-1:0] = user_sel_reg;
            end
            gio_pkg::OFS_USER_VAL: begin
                // Guarded selector keeps this in range
                rd_next[0] = (user_sel_reg < gio_pkg::USEL_W'(NUM_LINES))
                    ? user_bits_reg[user_sel_reg]
                    : group_bits_reg[2'(user_sel_reg - gio_pkg::USEL_W'(
                          NUM_LINES))];
            end
            default: begin
                rd_err = 1'b1;
            end
        endcase
    end

    // Writes to read-only or unmapped words, or out-of-range values
    always_comb begin
        wr_err = 1'b0;
        case (paddr)
            gio_pkg::OFS_LINE_SEL:
                wr_err = (pwdata >= gio_pkg::DATA_W'(NUM_LINES));
            gio_pkg::OFS_LINE_DIR:
                wr_err = (sel_info.kind != gio_pkg::GIO_KIND_BIDIR);
            gio_pkg::OFS_FILT_WIDTH:
                wr_err = (pwdata > gio_pkg::DATA_W'(
                    gio_pkg::FILT_MAX_STEPS));
            gio_pkg::OFS_OUT_SRC:
                wr_err = (pwdata >= gio_pkg::DATA_W'(NSRC));
            gio_pkg::OFS_USER_SEL:
                wr_err = (pwdata >= gio_pkg::DATA_W'(NUSR));
            gio_pkg::OFS_USER_VAL:
                wr_err = 1'b0;
            default:
                wr_err = 1'b1;
        endcase
    end

    // Read data captured in the setup cycle so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= pwrite ? '0 : rd_next;
        end
    end

    // Error captured with the request; address is stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= pwrite ? wr_err : rd_err;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // Zero wait states
    assign pready = 1'b1;

endmodule // gio_line_ctrl

// >>> verif/gio_line_ctrl_properties.sv
// Port-level assertion checker for the I/O line controller
`timescale 1ns/1ns
module gio_line_ctrl_checker #(
    parameter int NUM_LINES = 20
) (
    input wire logic                        pclk,
    input wire logic                        presetn,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic [gio_pkg::ADDR_W-1:0]  paddr,
    input wire logic [gio_pkg::DATA_W-1:0]  pwdata,
    input wire logic [gio_pkg::DATA_W-1:0]  prdata,
    input wire logic                        pready,
    input wire logic                        pslverr,
    input wire logic [gio_pkg::NUM_TMR-1:0] timer_wave,
    input wire logic [NUM_LINES-1:0]        line_in,
    input wire logic [NUM_LINES-1:0]        line_out,
    input wire logic [NUM_LINES-1:0]        line_oe
);
    // Masks hold for the large variant only
    localparam logic [19:0] IN_ONLY = 20'hc3f0f;
    localparam logic [19:0] OUT_FIX = 20'h300c0;
    localparam logic [19:0] BIDIR   = 20'h0c030;
    logic [4:0] sel_q;
    logic       src_wr;
    logic       tw_q;
    logic [2:0] tcnt;
    logic [1:0] rcnt;
    wire        setup  = psel && !penable;
    wire        wr_acc = psel && penable && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q  <= 5'h00;
            src_wr <= 1'b0;
        end else if (wr_acc) begin
            if (paddr == gio_pkg::OFS_LINE_SEL && pwdata < NUM_LINES)
                sel_q <= pwdata[4:0];
            if (paddr == gio_pkg::OFS_OUT_SRC)
                src_wr <= 1'b1;
        end
    end

    // Timer must sit still long enough to pass the synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tw_q <= 1'b0;
            tcnt <= 3'h0;
        end else begin
            tw_q <= timer_wave[0];
            if (timer_wave[0] != tw_q)
                tcnt <= 3'h0;
            else if (tcnt != 3'h7)
                tcnt <= tcnt + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rcnt <= 2'h0;
        else if (rcnt != 2'h3)
            rcnt <= rcnt + 2'h1;
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_in_no_oe;
        (line_oe & IN_ONLY) == 20'h0;
    endproperty
    a_in_no_oe: assert property (p_in_no_oe)
        else $error("input-only line driven");
    property p_out_oe;
        (line_oe & OUT_FIX) == OUT_FIX;
    endproperty
    a_out_oe: assert property (p_out_oe)
        else $error("fixed output line not driven");
    property p_quiet;
        (line_out & ~line_oe & ~$past(line_oe)) == 20'h0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("undriven line shows a level");
    property p_bidir_def;
        rcnt < 2'd2 |-> (line_oe & BIDIR) == 20'h0;
    endproperty
    a_bidir_def: assert property (p_bidir_def)
        else $error("bidirectional line not input after reset");
    property p_std;
        setup && !pwrite && paddr == gio_pkg::OFS_LVL_STD
            |=> prdata[31:2] == 30'h0 && prdata[1:0] != 2'b11;
    endproperty
    a_std: assert property (p_std)
        else $error("bad level standard code");
    property p_state_out;
        setup && !pwrite && paddr == gio_pkg::OFS_LINE_STATE
            |=> (prdata[19:0] & $past(line_oe)) == 20'h0;
    endproperty
    a_state_out: assert property (p_state_out)
        else $error("output line reads true");
    property p_tmr;
        !src_wr && tcnt > 3'd4 && timer_wave[0] == tw_q
            |-> (line_out & OUT_FIX) == (timer_wave[0] ? OUT_FIX : 20'h0);
    endproperty
    a_tmr: assert property (p_tmr)
        else $error("default source not timer zero");
    property p_dir_ro;
        setup && pwrite && paddr == gio_pkg::OFS_LINE_DIR && !BIDIR[sel_q]
            |=> pslverr;
    endproperty
    a_dir_ro: assert property (p_dir_ro)
        else $error("fixed direction write not refused");
    property p_sel;
        setup && !pwrite && paddr == gio_pkg::OFS_LINE_SEL
            |=> prdata == {27'h0, sel_q};
    endproperty
    a_sel: assert property (p_sel)
        else $error("line index reads wrong");

    c_src: cover property (wr_acc && paddr == gio_pkg::OFS_OUT_SRC);
    c_err: cover property (penable && pslverr);
    c_bidir: cover property ((line_oe & BIDIR) != 20'h0);
endmodule // gio_line_ctrl_checker

bind gio_line_ctrl gio_line_ctrl_checker #(.NUM_LINES(NUM_LINES)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_wave(timer_wave),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe)
);

// >>> verif/gio_ext_equip.sv
// Trigger and strobe equipment wired to the I/O lines
`timescale 1ns/1ns
module gio_ext_equip #(
    parameter int N   = 20,
    parameter int DLY = 1
) (
    input  wire logic         pclk,
    input  wire logic [N-1:0] want_lvl,
    input  wire logic [N-1:0] line_out,
    input  wire logic [N-1:0] line_oe,
    output logic      [N-1:0] line_in
);
    logic [N-1:0] lag [0:7];

    // Equipment answers late by DLY cycles
    always_ff @(posedge pclk) begin
        lag[0] <= want_lvl;
        for (int i = 1; i < 8; i++)
            lag[i] <= lag[i-1];
    end

    // Where the device drives, the wire shows the device
    always_comb begin
        for (int i = 0; i < N; i++)
            line_in[i] = line_oe[i] ? line_out[i]
                : (DLY == 0 ? want_lvl[i] : lag[(DLY > 0) ? DLY - 1 : 0][i]);
    end
endmodule // gio_ext_equip

// >>> verif/testbench.sv
// Self-checking bench for the I/O line controller, large variant
`timescale 1ns/1ns
module testbench;
    localparam int N = gio_pkg::LINES_LARGE;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  timer_wave = 4'h0;
    logic [N-1:0] want = 20'hc0300;
    logic [N-1:0] line_in;
    logic [N-1:0] line_out;
    logic [N-1:0] line_oe;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          checks = 0;
    int          p;

    always #50 pclk = ~pclk;

    gio_line_ctrl #(.NUM_LINES(N)) i_gio_line_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_wave(timer_wave),
        .line_in(line_in), .line_out(line_out), .line_oe(line_oe)
    );
    gio_ext_equip #(.N(N), .DLY(1)) i_gio_ext_equip (
        .pclk(pclk), .want_lvl(want), .line_out(line_out),
        .line_oe(line_oe), .line_in(line_in)
    );

    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            mismatches++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Pulse shorter than the filter window must never reach line 4
    task automatic glitch(input logic lvl);
        logic seen;
        seen = 1'b0;
        want[0] <= lvl;
        for (int i = 0; i < 22; i++) begin
            @(posedge pclk);
            if (i == 7)
                want[0] <= !lvl;
            seen = seen | (line_out[4] === lvl);
        end
        chk(seen, 0);
    endtask

    initial begin
        cyc(4);
        presetn <= 1'b1;
        rc(gio_pkg::OFS_LINE_SEL, 0);
        rc(gio_pkg::OFS_OUT_SRC, 2 * N);
        rc(gio_pkg::OFS_LINE_STATE, 32'h000c0300);
        timer_wave <= 4'h1;
        cyc(6);
        chk(line_out, 32'h000300c0);
        timer_wave <= 4'h0;
        for (int i = 0; i < N; i++) begin
            p = i % 10;
            wr(gio_pkg::OFS_LINE_SEL, i);
            rc(gio_pkg::OFS_LVL_STD, (p == 4 || p == 5) ? 1 : (p > 7) ? 2 : 0);
            rc(gio_pkg::OFS_LINE_DIR, {p == 4 || p == 5, p == 6 || p == 7});
            wr(gio_pkg::OFS_LINE_DIR, 0);
            chk(err, p != 4 && p != 5);
        end
        chk(line_oe, 32'h000300c0);
        wr(gio_pkg::OFS_LINE_SEL, N);
        chk(err, 1);
        rc(gio_pkg::OFS_LINE_SEL, N - 1);
        wr(8'h20, 1);
        chk(err, 1);
        rc(8'h20, 0);
        wr(gio_pkg::OFS_LINE_SEL, 4);
        wr(gio_pkg::OFS_LINE_DIR, 1);
        cyc(1);
        chk(line_oe, 32'h000300d0);
        rc(gio_pkg::OFS_LINE_DIR, 3);
        wr(gio_pkg::OFS_USER_SEL, 4);
        wr(gio_pkg::OFS_OUT_SRC, 4);
        for (int v = 1; v >= 0; v--) begin
            wr(gio_pkg::OFS_USER_VAL, v);
            cyc(3);
            chk(line_out[4], v);
        end
        for (int g = 0; g < 4; g++) begin
            wr(gio_pkg::OFS_USER_SEL, N + g);
            wr(gio_pkg::OFS_OUT_SRC, 2 * N + 4 + g);
            for (int v = 1; v >= 0; v--) begin
                wr(gio_pkg::OFS_USER_VAL, v);
                cyc(3);
                chk(line_out[4], v);
            end
        end
        for (int k = 0; k < 4; k++) begin
            wr(gio_pkg::OFS_OUT_SRC, 2 * N + k);
            for (int v = 0; v < 2; v++) begin
                timer_wave <= v ? (4'h1 << k) : ~(4'h1 << k);
                cyc(5);
                chk(line_out[4], v);
            end
        end
        wr(gio_pkg::OFS_OUT_SRC, 2 * N + 8);
        chk(err, 1);
        rc(gio_pkg::OFS_OUT_SRC, 2 * N + 3);
        wr(gio_pkg::OFS_OUT_SRC, N);
        want[0] <= 1'b1;
        cyc(9);
        chk(line_out[4], 1);
        rc(gio_pkg::OFS_LINE_STATE, 32'h000c0301);
        want[0] <= 1'b0;
        cyc(9);
        chk(line_out[4], 0);
        wr(gio_pkg::OFS_LINE_SEL, 0);
        wr(gio_pkg::OFS_FILT_WIDTH, 500001);
        chk(err, 1);
        wr(gio_pkg::OFS_FILT_WIDTH, 500000);
        rc(gio_pkg::OFS_FILT_WIDTH, 500000);
        wr(gio_pkg::OFS_FILT_WIDTH, 50);
        glitch(1'b1);
        want[0] <= 1'b1;
        cyc(18);
        chk(line_out[4], 1);
        glitch(1'b0);
        want[0] <= 1'b0;
        cyc(18);
        chk(line_out[4], 0);
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        chk(line_oe, 32'h000300c0);
        rc(gio_pkg::OFS_OUT_SRC, 2 * N);
        results();
    end
endmodule // testbench
